// ===== rtc_params.svh
// Constants for the reversal torque compensation block
//
// Overview of operation
// - Add compensation torque at each speed reversal
// - Bits 8/9 select type; both set prohibited
// - Amounts in current percent, range -1 to 200
// - Secondary zero: primary used both directions
// - Primary zero: secondary used both directions
// - Minus one disables that direction, and the other one too if it is zero
// - CW: plus-to-minus secondary; CCW swapped
// - Type 1 blocks overshoot and adaptive filter
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// ------------------------------------------------------------------
// Register map (word offsets on the register port)
// ------------------------------------------------------------------
`define RTC_ADDR_FEAT   4'h0
`define RTC_ADDR_PRIM   4'h1
`define RTC_ADDR_SEC    4'h2
`define RTC_ADDR_CTRL   4'h3
`define RTC_ADDR_STAT   4'h4

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define RTC_BIT_TYPE_LO 8
`define RTC_BIT_TYPE_HI 9
`define RTC_BIT_OVSA    10
`define RTC_BIT_OVSB    11
`define RTC_BIT_AFILT   12
`define RTC_BIT_CCW     0
`define RTC_BIT_RNGERR  2

// ------------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------------
`define RTC_RST_FEAT    16'h0000
`define RTC_RST_PRIM    16'sh0000
`define RTC_RST_SEC     16'sh0000
`define RTC_AMT_MIN     16'shffff
`define RTC_AMT_MAX     16'sh00c8
`define RTC_AMT_OFF     16'shffff
`define RTC_TQ_MAX      16'sh7fff
`define RTC_TQ_MIN      16'sh8000

`endif

// ===== rtc_pkg.sv
// Types shared by the reversal torque compensation files
package rtc_pkg;
  // Compensation type decoded from the feature select word
  typedef enum logic [1:0] {
    RTC_NONE,
    RTC_TYPE1,
    RTC_TYPE2,
    RTC_BAD
  } rtc_type_t;
endpackage

// ===== rtc_amount_sel.sv
// Effective amount for one reversal direction, with mirroring
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_amount_sel
  import rtc_pkg::*;
(
  input  wire logic signed [15:0] i_own,   // Amount for this direction
  input  wire logic signed [15:0] i_other, // Amount for other direction
  output logic signed [15:0]      o_amt    // Torque to add, 0 = none
);
  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  always_comb begin
    if (i_own == `RTC_AMT_OFF) begin
      o_amt = 16'sh0000;             // Direction disabled
    end else if (i_own == 16'sh0000) begin
      // Zero mirrors the other amount
      o_amt = (i_other == `RTC_AMT_OFF) ? 16'sh0000 : i_other;
    end else begin
      o_amt = i_own;                 // Own amount applies
    end
  end
endmodule

// ===== rtc_rev_detect.sv
// Detects a sign change of the commanded speed between samples
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_rev_detect
  import rtc_pkg::*;
(
  input  wire logic               i_clk,    // Control clock
  input  wire logic               i_rst_n,  // Async reset, low
  input  wire logic               i_valid,  // New speed sample
  input  wire logic signed [15:0] i_speed,  // Commanded speed
  output logic                    o_rev,    // Reversal this sample
  output logic                    o_to_neg  // New direction is minus
);
  logic last_neg_q;  // Sign of last nonzero sample
  logic have_dir_q;  // A nonzero sample has been seen
  logic nonzero;     // Current sample carries a direction

  // ----------------------------------------------------------------
  // Combinational detection
  // ----------------------------------------------------------------
  // Zero samples keep the old direction, so +,0,- still counts once
  always_comb begin
    nonzero  = (i_speed != 16'sh0000);
    o_to_neg = i_speed[15];
    o_rev    = i_valid && nonzero && have_dir_q &&
               (i_speed[15] != last_neg_q);
  end

  // ----------------------------------------------------------------
  // Direction memory
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_neg_q <= 1'b0;
      have_dir_q <= 1'b0;
    end else if (i_valid && nonzero) begin
      last_neg_q <= i_speed[15];
      have_dir_q <= 1'b1;
    end
  end
endmodule

// ===== rtc_top.sv
// Reversal torque compensation: registers, selection and adder
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_top
  import rtc_pkg::*;
(
  input  wire logic               I_CLOCK,        // 200 MHz clock
  input  wire logic               I_RST_N,        // Async reset, low
  input  wire logic [3:0]         I_ADDR,         // Register word index
  input  wire logic [15:0]        I_WR_DATA,      // Write data
  input  wire logic               I_WR,           // Write strobe
  input  wire logic               I_RD,           // Read strobe
  output logic [15:0]             O_RD_DATA,      // Read data, next cycle
  input  wire logic               I_SAMPLE_VALID, // Control sample pulse
  input  wire logic signed [15:0] I_SPEED_CMD,    // Commanded speed
  input  wire logic signed [15:0] I_TORQUE_CMD,   // Torque command, %
  output logic                    O_TORQUE_VALID, // Output sample pulse
  output logic signed [15:0]      O_TORQUE_OUT,   // Compensated torque
  output logic                    O_COMP_PULSE,   // Compensation applied
  output logic [1:0]              O_OVS_EN,       // Overshoot type bits
  output logic                    O_AFILT_EN      // Adaptive filter on
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0]        feat_q;      // Feature select word
  logic signed [15:0] prim_q;      // Primary amount
  logic signed [15:0] sec_q;       // Secondary amount
  logic               ccw_q;       // Rotation set to CCW
  logic               rng_err_q;   // Rejected out-of-range write
  logic [7:0]         rev_cnt_q;   // Reversals compensated
  logic [15:0]        rd_data_q;   // Read data register
  logic               tq_vld_q;    // Output valid register
  logic signed [15:0] tq_q;        // Output torque register
  logic               comp_q;      // Compensation pulse register
  rtc_type_t          ctype;       // Decoded compensation type
  logic               rev;         // Reversal in this sample
  logic               to_neg;      // Reversal toward minus
  logic signed [15:0] prim_eff;    // Amount for primary direction
  logic signed [15:0] sec_eff;     // Amount for secondary direction
  logic signed [15:0] add_mag;     // Amount chosen for this reversal
  logic signed [16:0] sum;         // Widened sum for saturation
  logic               apply;       // Compensation added now
  logic [15:0]        feat_wr;     // Feature word after masking
  logic               amt_ok;      // Write data within range
  logic               wr_feat;     // Write to feature word
  logic               wr_prim;     // Write to primary amount
  logic               wr_sec;      // Write to secondary amount

  // ----------------------------------------------------------------
  // Type decode and write qualification
  // ----------------------------------------------------------------
  // Both bits set is not allowed and behaves as no compensation
  always_comb begin
    unique case ({feat_q[`RTC_BIT_TYPE_HI], feat_q[`RTC_BIT_TYPE_LO]})
      2'b00: ctype = RTC_NONE;
      2'b01: ctype = RTC_TYPE1;
      2'b10: ctype = RTC_TYPE2;
      2'b11: ctype = RTC_BAD;
    endcase
  end

  // Range check against -1..200; out-of-range writes are dropped
  always_comb begin
    amt_ok  = ($signed(I_WR_DATA) >= `RTC_AMT_MIN) &&
              ($signed(I_WR_DATA) <= `RTC_AMT_MAX);
    wr_feat = I_WR && (I_ADDR == `RTC_ADDR_FEAT);
    wr_prim = I_WR && (I_ADDR == `RTC_ADDR_PRIM);
    wr_sec  = I_WR && (I_ADDR == `RTC_ADDR_SEC);
  end

  // Type 1 forces the overshoot and filter bits off on any write
  always_comb begin
    feat_wr = I_WR_DATA;
    if (I_WR_DATA[`RTC_BIT_TYPE_LO] && !I_WR_DATA[`RTC_BIT_TYPE_HI])
    begin
      feat_wr[`RTC_BIT_OVSA]  = 1'b0;
      feat_wr[`RTC_BIT_OVSB]  = 1'b0;
      feat_wr[`RTC_BIT_AFILT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      feat_q <= `RTC_RST_FEAT;
    end else if (wr_feat) begin
      feat_q <= feat_wr;
    end
  end

  // Amounts keep their old value on a rejected write
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      prim_q <= `RTC_RST_PRIM;
      sec_q  <= `RTC_RST_SEC;
    end else begin
      if (wr_prim && amt_ok) begin
        prim_q <= $signed(I_WR_DATA);
      end
      if (wr_sec && amt_ok) begin
        sec_q <= $signed(I_WR_DATA);
      end
    end
  end

  // Rotation setting, common to every axis served
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ccw_q <= 1'b0;
    end else if (I_WR && (I_ADDR == `RTC_ADDR_CTRL)) begin
      ccw_q <= I_WR_DATA[`RTC_BIT_CCW];
    end
  end

  // Sticky range error; a new error wins over a clear
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rng_err_q <= 1'b0;
    end else if ((wr_prim || wr_sec) && !amt_ok) begin
      rng_err_q <= 1'b1;
    end else if (I_WR && (I_ADDR == `RTC_ADDR_STAT) &&
                 I_WR_DATA[`RTC_BIT_RNGERR]) begin
      rng_err_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stand one cycle only; unmapped indexes read zero
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rd_data_q <= 16'h0000;
    end else if (I_RD) begin
      unique case (I_ADDR)
        `RTC_ADDR_FEAT: rd_data_q <= feat_q;
        `RTC_ADDR_PRIM: rd_data_q <= prim_q;
        `RTC_ADDR_SEC:  rd_data_q <= sec_q;
        `RTC_ADDR_CTRL: rd_data_q <= {15'h0000, ccw_q};
        `RTC_ADDR_STAT: rd_data_q <= {rev_cnt_q, 5'h00, rng_err_q,
                                      ctype};
        default:        rd_data_q <= 16'h0000;
      endcase
    end else begin
      rd_data_q <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Reversal detection and amount selection
  // ----------------------------------------------------------------
  rtc_rev_detect u_rev (
    .i_clk    (I_CLOCK),
    .i_rst_n  (I_RST_N),
    .i_valid  (I_SAMPLE_VALID),
    .i_speed  (I_SPEED_CMD),
    .o_rev    (rev),
    .o_to_neg (to_neg)
  );

  rtc_amount_sel u_prim (
    .i_own   (prim_q),
    .i_other (sec_q),
    .o_amt   (prim_eff)
  );

  rtc_amount_sel u_sec (
    .i_own   (sec_q),
    .i_other (prim_q),
    .o_amt   (sec_eff)
  );

  // CW: plus-to-minus takes secondary, minus-to-plus primary
  always_comb begin
    if (to_neg) begin
      add_mag = ccw_q ? prim_eff : sec_eff;
    end else begin
      add_mag = ccw_q ? sec_eff : prim_eff;
    end
    apply = rev && ((ctype == RTC_TYPE1) || (ctype == RTC_TYPE2)) &&
            (add_mag != 16'sh0000);
    // Torque is pushed in the new direction of travel
    if (!apply) begin
      sum = {I_TORQUE_CMD[15], I_TORQUE_CMD};
    end else if (to_neg) begin
      sum = {I_TORQUE_CMD[15], I_TORQUE_CMD} -
            {add_mag[15], add_mag};
    end else begin
      sum = {I_TORQUE_CMD[15], I_TORQUE_CMD} +
            {add_mag[15], add_mag};
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // One register stage; saturation avoids wrap on large commands
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tq_q     <= 16'sh0000;
      tq_vld_q <= 1'b0;
      comp_q   <= 1'b0;
    end else begin
      tq_vld_q <= I_SAMPLE_VALID;
      comp_q   <= apply;
      if (I_SAMPLE_VALID) begin
        if (sum[16] != sum[15]) begin
          tq_q <= sum[16] ? `RTC_TQ_MIN : `RTC_TQ_MAX;
        end else begin
          tq_q <= sum[15:0];
        end
      end
    end
  end

  // Count of compensated reversals, wraps
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rev_cnt_q <= 8'h00;
    end else if (apply) begin
      rev_cnt_q <= rev_cnt_q + 8'h01;
    end
  end

  assign O_RD_DATA      = rd_data_q;
  assign O_TORQUE_VALID = tq_vld_q;
  assign O_TORQUE_OUT   = tq_q;
  assign O_COMP_PULSE   = comp_q;
  assign O_OVS_EN       = {feat_q[`RTC_BIT_OVSB], feat_q[`RTC_BIT_OVSA]};
  assign O_AFILT_EN     = feat_q[`RTC_BIT_AFILT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic signed [15:0] chk_tq_q;   // Torque command of last sample
  logic signed [16:0] chk_delta;  // Added torque seen at the output
  logic               chk_small;  // Command far from saturation

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      chk_tq_q <= 16'sh0000;
    end else if (I_SAMPLE_VALID) begin
      chk_tq_q <= I_TORQUE_CMD;
    end
  end

  always_comb begin
    chk_delta = {O_TORQUE_OUT[15], O_TORQUE_OUT} -
                {chk_tq_q[15], chk_tq_q};
    chk_small = (I_TORQUE_CMD < 16'sh03e8) &&
                (I_TORQUE_CMD > -16'sh03e8);
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  property p_no_rev_pass;
    I_SAMPLE_VALID && !rev |=> O_TORQUE_VALID && chk_delta == 17'sh0;
  endproperty
  a_no_rev_pass: assert property (p_no_rev_pass)
    else $error("torque altered without reversal");

  property p_prohib;
    I_SAMPLE_VALID && ctype == RTC_BAD |=> chk_delta == 17'sh0;
  endproperty
  a_prohib: assert property (p_prohib)
    else $error("prohibited type compensated");

  property p_amt_range;
    prim_q >= `RTC_AMT_MIN && prim_q <= `RTC_AMT_MAX &&
    sec_q >= `RTC_AMT_MIN && sec_q <= `RTC_AMT_MAX;
  endproperty
  a_amt_range: assert property (p_amt_range)
    else $error("amount outside allowed range");

  property p_mirror_prim;
    I_SAMPLE_VALID && rev && chk_small && ctype == RTC_TYPE2 &&
    sec_q == 16'sh0 && prim_q > 16'sh0 && !to_neg
    |=> chk_delta == {$past(prim_q[15]), $past(prim_q)} && O_COMP_PULSE;
  endproperty
  a_mirror_prim: assert property (p_mirror_prim)
    else $error("primary not mirrored");

  property p_mirror_sec;
    I_SAMPLE_VALID && rev && chk_small && ctype == RTC_TYPE1 &&
    prim_q == 16'sh0 && sec_q > 16'sh0 && to_neg
    |=> chk_delta == -{$past(sec_q[15]), $past(sec_q)} && O_COMP_PULSE;
  endproperty
  a_mirror_sec: assert property (p_mirror_sec)
    else $error("secondary not mirrored");

  property p_dir_off;
    I_SAMPLE_VALID && rev && !ccw_q && to_neg && sec_q == `RTC_AMT_OFF
    |=> chk_delta == 17'sh0 && !O_COMP_PULSE;
  endproperty
  a_dir_off: assert property (p_dir_off)
    else $error("disabled direction compensated");

  property p_cw_map;
    I_SAMPLE_VALID && rev && chk_small && !ccw_q && to_neg &&
    ctype == RTC_TYPE2 && prim_q > 16'sh0 && sec_q > 16'sh0
    |=> chk_delta == -{$past(sec_q[15]), $past(sec_q)};
  endproperty
  a_cw_map: assert property (p_cw_map)
    else $error("wrong amount for CW reversal");

  property p_type1_mask;
    ctype == RTC_TYPE1 |-> O_OVS_EN == 2'b00 && !O_AFILT_EN;
  endproperty
  a_type1_mask: assert property (p_type1_mask)
    else $error("overshoot or filter on under type 1");

  property p_zero_speed;
    I_SAMPLE_VALID && I_SPEED_CMD == 16'sh0 |=> !O_COMP_PULSE;
  endproperty
  a_zero_speed: assert property (p_zero_speed)
    else $error("zero speed counted as reversal");

  c_comp_neg: cover property (I_SAMPLE_VALID && apply && to_neg);
  c_comp_pos: cover property (I_SAMPLE_VALID && apply && !to_neg);
  c_ccw_comp: cover property (apply && ccw_q);
  c_rng_err:  cover property ($rose(rng_err_q));
endmodule

// ===== rtc_nc_model.sv
// Controller model that sends speed and torque samples to the drive
`timescale 1ns/1ps
module rtc_nc_model (
  input  wire logic               i_clk,   // Control clock
  input  wire logic               i_rst_n, // Async reset, low
  input  wire logic               i_req,   // Queue one sample
  input  wire logic signed [15:0] i_spd,   // Speed to send
  input  wire logic signed [15:0] i_tq,    // Torque to send
  input  wire logic [2:0]         i_gap,   // Idle cycles before sending
  output logic                    o_valid, // Sample strobe
  output logic signed [15:0]      o_spd,   // Speed line
  output logic signed [15:0]      o_tq     // Torque line
);
  // ----------------------------------------------------------------
  // Pending sample
  // ----------------------------------------------------------------
  logic               pend_q; // Sample waiting to go out
  logic [2:0]         cnt_q;  // Idle cycles still to wait
  logic signed [15:0] spd_q;  // Held speed
  logic signed [15:0] tq_q;   // Held torque

  // Lines toggle outside the strobe, so stale data is never mistaken
  // for a held sample; a new request overwrites one still waiting
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q  <= 1'b0;
      cnt_q   <= 3'h0;
      spd_q   <= 16'h0000;
      tq_q    <= 16'h0000;
      o_valid <= 1'b0;
      o_spd   <= 16'h0000;
      o_tq    <= 16'h0000;
    end else begin
      o_valid <= 1'b0;
      o_spd   <= ~o_spd;
      o_tq    <= ~o_tq;
      if (pend_q && cnt_q == 3'h0) begin
        o_valid <= 1'b1;
        o_spd   <= spd_q;
        o_tq    <= tq_q;
        pend_q  <= 1'b0;
      end else if (pend_q) begin
        cnt_q <= cnt_q - 3'h1;
      end
      if (i_req) begin
        pend_q <= 1'b1;
        cnt_q  <= i_gap;
        spd_q  <= i_spd;
        tq_q   <= i_tq;
      end
    end
  end
endmodule

// ===== test_reversal_torque_compensation.sv
// Self-checking bench for the reversal torque compensation block
`timescale 1ns/1ps
module test_reversal_torque_compensation;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic               I_CLOCK = 1'b0;     // 200 MHz clock
  logic               I_RST_N = 1'b0;     // Reset, low
  logic [3:0]         I_ADDR = 4'h0;      // Register index
  logic [15:0]        I_WR_DATA = 16'h0;  // Write data
  logic               I_WR = 1'b0;        // Write strobe
  logic               I_RD = 1'b0;        // Read strobe
  logic [15:0]        O_RD_DATA;          // Read data
  logic               I_SAMPLE_VALID;     // From controller model
  logic signed [15:0] I_SPEED_CMD;        // From controller model
  logic signed [15:0] I_TORQUE_CMD;       // From controller model
  logic               O_TORQUE_VALID;     // Output strobe
  logic signed [15:0] O_TORQUE_OUT;       // Compensated torque
  logic               O_COMP_PULSE;       // Amount added
  logic [1:0]         O_OVS_EN;           // Overshoot bits
  logic               O_AFILT_EN;         // Adaptive filter
  logic               nc_req = 1'b0;      // Model request
  logic [15:0]        nc_spd = 16'h0;     // Model speed
  logic [15:0]        nc_tq = 16'h0;      // Model torque
  logic [2:0]         nc_gap = 3'h0;      // Model delay
  int                 fail_count = 0;     // Mismatches
  int                 tests_run = 0;      // Comparisons

  // Table row: type, amounts, speed, torque, result, {ccw, pulse}
  typedef struct packed {
    logic [1:0]  typ;
    logic [15:0] prim;
    logic [15:0] sec;
    logic [15:0] spd;
    logic [15:0] tq;
    logic [15:0] exp;
    logic [1:0]  fl;
  } rtc_row_t;
  // Expected output sample and whether to compare it
  typedef struct packed {
    logic        chk;
    logic        pls;
    logic [15:0] val;
  } rtc_exp_t;

  // Amounts tuned in steps of five, as a controller would
  localparam rtc_row_t ROWS [15] = '{
    '{2'h2,16'h0028,16'h0000,16'h0005,16'h000a,16'h0032,2'h1},
    '{2'h2,16'h0028,16'h0000,16'hfffb,16'h000a,16'hffe2,2'h1},
    '{2'h1,16'h0000,16'h001e,16'hfffb,16'h0000,16'hffe2,2'h1},
    '{2'h1,16'h0000,16'h001e,16'h0005,16'h0000,16'h001e,2'h1},
    '{2'h2,16'h0028,16'hffff,16'hfffb,16'h0005,16'h0005,2'h0},
    '{2'h2,16'h0028,16'hffff,16'h0005,16'h0005,16'h002d,2'h1},
    '{2'h2,16'h0028,16'h0014,16'hfffb,16'h0000,16'hffd8,2'h3},
    '{2'h2,16'h0028,16'h0014,16'h0005,16'h0000,16'h0014,2'h3},
    '{2'h2,16'h0028,16'h0014,16'hfffb,16'h0000,16'hffec,2'h1},
    '{2'h2,16'h0028,16'h0014,16'h0005,16'h0000,16'h0028,2'h1},
    '{2'h0,16'h0028,16'h0014,16'h0005,16'h0007,16'h0007,2'h0},
    '{2'h3,16'h0028,16'h0014,16'h0005,16'h0007,16'h0007,2'h0},
    '{2'h2,16'h0028,16'h0014,16'h0000,16'h0007,16'h0007,2'h0},
    '{2'h2,16'h00c8,16'h0000,16'h0005,16'h7ff0,16'h7fff,2'h1},
    '{2'h2,16'h00c8,16'h0000,16'hfffb,16'h8010,16'h8000,2'h1}
  };
  // Range boundaries: accepted, rejected, accepted, rejected
  localparam logic [15:0] AMT [4] = '{16'h00c8, 16'h00c9, 16'hffff,
                                      16'hfffe};

  rtc_exp_t    exp_q [$]; // Samples in flight
  rtc_exp_t    x;         // Popped expectation
  rtc_row_t    r;         // Current row
  logic [15:0] prev;      // Speed that sets the direction
  logic [15:0] d;         // Read result
  logic [15:0] e;         // Expected word

  // ----------------------------------------------------------------
  // Design and controller model
  // ----------------------------------------------------------------
  rtc_top i_dut (
    .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
    .I_WR_DATA(I_WR_DATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RD_DATA(O_RD_DATA), .I_SAMPLE_VALID(I_SAMPLE_VALID),
    .I_SPEED_CMD(I_SPEED_CMD), .I_TORQUE_CMD(I_TORQUE_CMD),
    .O_TORQUE_VALID(O_TORQUE_VALID), .O_TORQUE_OUT(O_TORQUE_OUT),
    .O_COMP_PULSE(O_COMP_PULSE), .O_OVS_EN(O_OVS_EN),
    .O_AFILT_EN(O_AFILT_EN));

  rtc_nc_model i_nc (
    .i_clk(I_CLOCK), .i_rst_n(I_RST_N), .i_req(nc_req),
    .i_spd(nc_spd), .i_tq(nc_tq), .i_gap(nc_gap),
    .o_valid(I_SAMPLE_VALID), .o_spd(I_SPEED_CMD), .o_tq(I_TORQUE_CMD));

  // Clock generator
  always #2.5 I_CLOCK = ~I_CLOCK;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk16(input string n, input logic [15:0] ev,
                       input logic [15:0] gv);
    tests_run++;
    if (gv !== ev) begin
      fail_count++;
      $display("ERROR %s expected %h got %h", n, ev, gv);
    end
  endtask

  task automatic chk1(input string n, input logic ev, input logic gv);
    tests_run++;
    if (gv !== ev) begin
      fail_count++;
      $display("ERROR %s expected %b got %b", n, ev, gv);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge I_CLOCK);
    I_WR      <= 1'b1;
    I_ADDR    <= a;
    I_WR_DATA <= v;
    @(posedge I_CLOCK);
    I_WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge I_CLOCK);
    I_RD   <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLOCK);
    I_RD <= 1'b0;
    #1 v = O_RD_DATA;
  endtask

  // Queue one sample; calls on successive edges with zero gap give back-to-back
  task automatic smp(input logic [15:0] s, input logic [15:0] t,
                     input logic [15:0] ev, input logic p,
                     input logic c, input logic [2:0] g);
    @(posedge I_CLOCK);
    nc_req <= 1'b1;
    nc_spd <= s;
    nc_tq  <= t;
    nc_gap <= g;
    exp_q.push_back('{c, p, ev});
  endtask

  // Stop requesting and wait, bounded, for every answer
  task automatic drain();
    int n;
    n = 0;
    @(posedge I_CLOCK);
    nc_req <= 1'b0;
    while (exp_q.size() != 0 && n < 40) begin
      @(posedge I_CLOCK);
      n++;
    end
    chk16("pending_samples", 16'h0000, 16'(exp_q.size()));
  endtask

  // Every output strobe pops the oldest queued sample; flagged ones must match it
  always @(posedge I_CLOCK) begin
    if (O_TORQUE_VALID === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk1("unexpected_valid", 1'b0, 1'b1);
      end else begin
        x = exp_q.pop_front();
        if (x.chk) begin
          chk16("torque_out", x.val, O_TORQUE_OUT);
          chk1("comp_pulse", x.pls, O_COMP_PULSE);
        end
      end
    end
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge I_CLOCK);
    fail_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge I_CLOCK);
    I_RST_N <= 1'b1;
    // Registers clear after reset
    for (int a = 0; a < 5; a++) begin
      rd(4'(a), d);
      chk16("reg_reset", 16'h0000, d);
    end
    // First sample only sets the direction
    wr(4'h0, 16'h0200);
    wr(4'h1, 16'h0028);
    smp(16'h0005, 16'h0003, 16'h0003, 1'b0, 1'b1, 3'h0);
    drain();
    // Table of reversal cases plus one zero-speed row, with varying controller delay
    for (int i = 0; i < 15; i++) begin
      r = ROWS[i];
      prev = (r.spd == 16'h0000) ? 16'h0003 : -r.spd;
      wr(4'h0, {6'h00, r.typ, 8'h00});
      wr(4'h3, {15'h0000, r.fl[1]});
      wr(4'h1, r.prim);
      wr(4'h2, r.sec);
      smp(prev, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'(i % 3));
      drain();
      smp(r.spd, r.tq, r.exp, r.fl[0], 1'b1, 3'(i % 3));
      drain();
    end
    // Amount range edges; rejected writes leave the old value
    for (int k = 0; k < 4; k++) begin
      wr(4'h1, AMT[k]);
      rd(4'h1, d);
      chk16("prim_amount", AMT[k & 2], d);
      rd(4'h4, d);
      chk1("range_error", 1'(k % 2), d[2]);
      wr(4'h4, 16'h0004);
    end
    // Type codes; type 1 blocks overshoot and filter bits
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, {6'h07, 2'(k), 8'h00});
      rd(4'h0, d);
      e = (k == 1) ? 16'h0100 : {6'h07, 2'(k), 8'h00};
      chk16("feature_word", e, d);
      e = (k == 1) ? 16'h0000 : 16'h0007;
      chk16("ovs_afilt", e, {13'h0000, O_AFILT_EN, O_OVS_EN});
      rd(4'h4, d);
      chk16("type_code", 16'(k), {14'h0000, d[1:0]});
    end
    // Read data fall back to zero one cycle after the answer
    @(posedge I_CLOCK);
    #1 chk16("rd_idle", 16'h0000, O_RD_DATA);
    // Unmapped index ignores writes and reads zero
    wr(4'h5, 16'h1234);
    rd(4'h5, d);
    chk16("unmapped", 16'h0000, d);
    // Zero sample in mid-reversal, then samples every cycle
    wr(4'h0, 16'h0200);
    wr(4'h3, 16'h0000);
    wr(4'h1, 16'h0028);
    wr(4'h2, 16'h0014);
    smp(16'h0005, 16'h0000, 16'h0000, 1'b0, 1'b0, 3'h0);
    smp(16'h0000, 16'h0001, 16'h0001, 1'b0, 1'b1, 3'h0);
    smp(16'hfffb, 16'h0000, 16'hffec, 1'b1, 1'b1, 3'h0);
    smp(16'h0005, 16'h0000, 16'h0028, 1'b1, 1'b1, 3'h0);
    smp(16'hfffb, 16'h0000, 16'hffec, 1'b1, 1'b1, 3'h0);
    drain();
    // Eighteen reversals were compensated over the whole run
    rd(4'h4, d);
    chk16("rev_count", 16'h0012, {8'h00, d[15:8]});
    test_done();
  end
endmodule
